// [inc/wcr_pkg.sv]
// constants for the wake clock recovery configuration block
package wcr_pkg;
	// register bus frame layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FRAME_BITS = 16;
	localparam int MODE_POS = 7;
	localparam int DATA_LSB = 8;
	localparam logic [4:0] FRAME_LEN = 5'h10;
	localparam logic [4:0] DATA_START = 5'h08;
	// register addresses
	localparam logic [6:0] ADDR_CAL_HIGH = 7'h3a;
	localparam logic [6:0] ADDR_CAL_LOW = 7'h3b;
	localparam logic [6:0] ADDR_CTRL_ONE = 7'h3c;
	localparam logic [6:0] ADDR_CTRL_TWO = 7'h3d;
	// reset values
	localparam logic [7:0] CAL_RESET = 8'h00;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
	// field positions
	localparam int EN_POS = 0;
	localparam int FILT_LSB = 2;
	localparam int FILT_MSB = 3;
	localparam int CLKSEL_LSB = 0;
	localparam int CLKSEL_MSB = 1;
	// filter time constant selections and their shift amounts
	localparam logic [1:0] FILT_TC8 = 2'h0;
	localparam logic [1:0] FILT_TC16 = 2'h1;
	localparam logic [1:0] FILT_TC32 = 2'h2;
	localparam logic [1:0] FILT_ADAPT = 2'h3;
	localparam logic [2:0] SHIFT_TC8 = 3'h3;
	localparam logic [2:0] SHIFT_TC16 = 3'h4;
	localparam logic [2:0] SHIFT_TC32 = 3'h5;
	// recovery clock rates against the system clock, in MHz
	localparam logic [8:0] SYS_CLK_MHZ = 9'd250;
	localparam logic [8:0] REC_MHZ_80 = 9'd80;
	localparam logic [8:0] REC_MHZ_40 = 9'd40;
	localparam logic [8:0] REC_MHZ_20 = 9'd20;
	localparam logic [8:0] REC_MHZ_10 = 9'd10;
	// recovery datapath widths
	localparam int SPAN_W = 12;
	localparam int FRAC_W = 8;
	localparam int SYNC_N = 3;
endpackage : wcr_pkg

// [inc/wcr_if.sv]
// carrier between the serial frame decoder and the register file
interface wcr_if;
	logic wr_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport frame (output wr_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : wcr_if

// [rtl/wcr_spi_frame.sv]
// serial frame decoder: pin synchronisers, 16-bit frame capture and read shift-out
module wcr_spi_frame
	import wcr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_pin,
	input wire logic csn_pin,
	input wire logic sdi_pin,
	output logic sdo,
	output logic sdo_oe_n,
	wcr_if.frame bus
);
	logic [2:0] pin_raw;
	logic [2:0] s1_q, s2_q, s3_q, stable_q, prev_q;
	logic [4:0] cnt_q;
	logic [FRAME_BITS-1:0] rx_q;
	logic [DATA_W-1:0] tx_q;
	logic wr_q;
	logic sclk_rise, sclk_fall, csn_fall, csn_rise, sdi_s, frame_act;
	// idle levels of {sclk, csn, sdi}; a reset value off the idle level would fake an edge
	localparam logic [2:0] PIN_IDLE = 3'h3;

	assign pin_raw = {sclk_pin, csn_pin, sdi_pin};

	// three-stage synchronisers; a change counts once stages two and three agree
	for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_q[i] <= PIN_IDLE[i];
				s2_q[i] <= PIN_IDLE[i];
				s3_q[i] <= PIN_IDLE[i];
				stable_q[i] <= PIN_IDLE[i];
				prev_q[i] <= PIN_IDLE[i];
			end else begin
				s1_q[i] <= pin_raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) stable_q[i] <= s3_q[i];
				prev_q[i] <= stable_q[i];
			end
		end
	end

	// edge decode on the filtered pins
	assign sclk_rise = stable_q[2] & ~prev_q[2];
	assign sclk_fall = ~stable_q[2] & prev_q[2];
	assign csn_fall = ~stable_q[1] & prev_q[1];
	assign csn_rise = stable_q[1] & ~prev_q[1];
	assign sdi_s = stable_q[0];
	assign frame_act = ~stable_q[1];

	// frame capture: address, access bit, data byte, first bit first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			rx_q <= '0;
		end else if (csn_fall) begin
			cnt_q <= '0;
		end else if (frame_act && sclk_rise && cnt_q < FRAME_LEN) begin
			rx_q[cnt_q[3:0]] <= sdi_s;
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// write only for a complete frame with the access bit set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) wr_q <= 1'b0;
		else wr_q <= csn_rise && cnt_q == FRAME_LEN && rx_q[MODE_POS];
	end

	// read data replaces the second byte, shifted out on falling clock edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= '0;
			sdo <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else begin
			sdo_oe_n <= ~frame_act;
			if (csn_fall) begin
				sdo <= 1'b0;
			end else if (frame_act && sclk_rise && cnt_q == DATA_START - 5'h01) begin
				tx_q <= bus.rdata; // address known after its last bit
			end else if (frame_act && sclk_fall && cnt_q >= DATA_START) begin
				sdo <= tx_q[0];
				tx_q <= {1'b0, tx_q[DATA_W-1:1]};
			end
		end
	end

	assign bus.wr_stb = wr_q;
	assign bus.addr = {sdi_s && cnt_q == 5'h06 ? 1'b1 : rx_q[6], rx_q[5:0]};
	assign bus.wdata = rx_q[FRAME_BITS-1:DATA_LSB];
endmodule : wcr_spi_frame

// [rtl/wcr_top.sv]
// wake clock recovery configuration registers and recovery datapath
// Summary of operation
// - upper calibration byte is read-only and resets to zero
// - lower calibration byte is read-only and resets to zero
// - filter field bits 3:2 pick constant 8, 16 (default) or 32
// - filter value 11 adapts constant from falling-edge spacing in bits
// - unused control bits always read back as zero
// - clock select picks 80, 40, 20 or 10 MHz recovery counter clock
// - recovered bit time is clamped between upper and lower limits
// - each access is a 16-bit frame: address, mode bit, data
module wcr_top
	import wcr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic SOFT_RESET,
	input wire logic SCLK,
	input wire logic CSN,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE_N,
	input wire logic CAL_LOAD,
	input wire logic [7:0] CAL_HIGH_IN,
	input wire logic [7:0] CAL_LOW_IN,
	input wire logic RXD,
	input wire logic [7:0] NOMINAL_BIT_TIME,
	input wire logic [7:0] BIT_TIME_UPPER_LIMIT,
	input wire logic [7:0] BIT_TIME_LOWER_LIMIT,
	output logic RECOVERY_ENABLE,
	output logic [1:0] RECOVERY_CLOCK_SELECT,
	output logic [5:0] FILTER_CONSTANT,
	output logic RECOVERY_TICK,
	output logic [7:0] RECOVERED_BIT_TIME
);
	wcr_if bus ();

	logic [7:0] calib_high_byte, calib_low_byte;
	logic recovery_enable_q;
	logic [1:0] filter_constant_select_q;
	logic [1:0] recovery_clock_select_q;
	logic [7:0] ctrl_one_rd, ctrl_two_rd;

	wcr_spi_frame u_frame (
		.clk(CLOCK),
		.rst_n(RSTN),
		.sclk_pin(SCLK),
		.csn_pin(CSN),
		.sdi_pin(SDI),
		.sdo(SDO),
		.sdo_oe_n(SDO_OE_N),
		.bus(bus)
	);

	// write decode; calibration addresses have no write path
	logic wr_one, wr_two;
	assign wr_one = bus.wr_stb && bus.addr == ADDR_CTRL_ONE;
	assign wr_two = bus.wr_stb && bus.addr == ADDR_CTRL_TWO;

	// calibration result bytes, loaded only by the oscillator calibration
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			calib_high_byte <= CAL_RESET;
			calib_low_byte <= CAL_RESET;
		end else if (SOFT_RESET) begin
			calib_high_byte <= CAL_RESET;
			calib_low_byte <= CAL_RESET;
		end else if (CAL_LOAD) begin
			calib_high_byte <= CAL_HIGH_IN;
			calib_low_byte <= CAL_LOW_IN;
		end
	end

	// control registers; only defined fields are stored
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			recovery_enable_q <= CTRL_ONE_RESET[EN_POS];
			filter_constant_select_q <= CTRL_ONE_RESET[FILT_MSB:FILT_LSB];
			recovery_clock_select_q <= CTRL_TWO_RESET[CLKSEL_MSB:CLKSEL_LSB];
		end else if (SOFT_RESET) begin
			recovery_enable_q <= CTRL_ONE_RESET[EN_POS];
			filter_constant_select_q <= CTRL_ONE_RESET[FILT_MSB:FILT_LSB];
			recovery_clock_select_q <= CTRL_TWO_RESET[CLKSEL_MSB:CLKSEL_LSB];
		end else begin
			if (wr_one) begin
				recovery_enable_q <= bus.wdata[EN_POS];
				filter_constant_select_q <= bus.wdata[FILT_MSB:FILT_LSB];
			end
			if (wr_two) recovery_clock_select_q <= bus.wdata[CLKSEL_MSB:CLKSEL_LSB];
		end
	end

	// read multiplexer; reserved positions are forced to zero
	assign ctrl_one_rd = {4'h0, filter_constant_select_q, 1'b0, recovery_enable_q};
	assign ctrl_two_rd = {6'h00, recovery_clock_select_q};
	assign bus.rdata = bus.addr == ADDR_CAL_HIGH ? calib_high_byte :
		bus.addr == ADDR_CAL_LOW ? calib_low_byte :
		bus.addr == ADDR_CTRL_ONE ? ctrl_one_rd :
		bus.addr == ADDR_CTRL_TWO ? ctrl_two_rd : 8'h00;

	// recovery counter clock rate for each selection
	function automatic logic [8:0] rec_rate(input logic [1:0] sel);
		case (sel)
			2'h0: rec_rate = REC_MHZ_80;
			2'h1: rec_rate = REC_MHZ_40;
			2'h2: rec_rate = REC_MHZ_20;
			default: rec_rate = REC_MHZ_10;
		endcase
	endfunction : rec_rate

	// fractional divider: ticks at the selected rate out of the system clock
	logic [8:0] phase_q, phase_sum;
	logic tick;
	assign phase_sum = phase_q + rec_rate(recovery_clock_select_q);
	assign tick = recovery_enable_q && phase_sum >= SYS_CLK_MHZ;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) phase_q <= '0;
		else if (!recovery_enable_q) phase_q <= '0;
		else if (tick) phase_q <= phase_sum - SYS_CLK_MHZ;
		else phase_q <= phase_sum;
	end

	// receive line synchroniser, stages two and three must agree
	logic rx_s1_q, rx_s2_q, rx_s3_q, rx_st_q, rx_prev_q, rx_fall;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_st_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_s1_q <= RXD;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q) rx_st_q <= rx_s3_q;
			rx_prev_q <= rx_st_q;
		end
	end
	assign rx_fall = rx_prev_q & ~rx_st_q;

	// spacing thresholds in ticks, halfway between whole bit counts
	logic [SPAN_W-1:0] nom, thr25, thr35, thr85, thr105;
	assign nom = {4'h0, NOMINAL_BIT_TIME};
	assign thr25 = SPAN_W'((nom * 5) >> 1);
	assign thr35 = SPAN_W'((nom * 7) >> 1);
	assign thr85 = SPAN_W'((nom * 17) >> 1);
	assign thr105 = SPAN_W'((nom * 21) >> 1);

	// tick count since the last falling edge, saturating
	logic [SPAN_W-1:0] span_q;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) span_q <= '0;
		else if (!recovery_enable_q || rx_fall) span_q <= '0;
		else if (tick && span_q != '1) span_q <= span_q + SPAN_W'(1);
	end

	// adaptive constant: 2-3 bits gives 32, 4-8 gives 16, 9-10 gives 8
	logic [2:0] adapt_shift_q, adapt_next, shift_sel;
	assign adapt_next = span_q < thr35 ? SHIFT_TC32 :
		span_q < thr85 ? SHIFT_TC16 :
		span_q < thr105 ? SHIFT_TC8 : adapt_shift_q;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) adapt_shift_q <= SHIFT_TC16;
		else if (!recovery_enable_q) adapt_shift_q <= SHIFT_TC16;
		else if (rx_fall) adapt_shift_q <= adapt_next;
	end

	// filter constant chosen by the filter field
	assign shift_sel = filter_constant_select_q == FILT_TC8 ? SHIFT_TC8 :
		filter_constant_select_q == FILT_TC16 ? SHIFT_TC16 :
		filter_constant_select_q == FILT_TC32 ? SHIFT_TC32 : adapt_shift_q;

	// one bit-time sample from a two-bit spacing, saturated to a byte
	logic [SPAN_W-1:0] half_span;
	logic [7:0] sample;
	logic take;
	assign half_span = span_q >> 1;
	assign sample = half_span > SPAN_W'(8'hff) ? 8'hff : half_span[7:0];
	assign take = rx_fall && span_q < thr25 && span_q >= nom;

	// low-pass filter on the bit time, then clamp to the limits
	logic [15:0] bt_q, bt_new, bt_clamped;
	logic signed [16:0] diff;
	assign diff = $signed({1'b0, sample, 8'h00}) - $signed({1'b0, bt_q});
	assign bt_new = 16'(bt_q + 16'(diff >>> shift_sel));
	assign bt_clamped = bt_new[15:8] > BIT_TIME_UPPER_LIMIT ? {BIT_TIME_UPPER_LIMIT, 8'h00} :
		bt_new[15:8] < BIT_TIME_LOWER_LIMIT ? {BIT_TIME_LOWER_LIMIT, 8'h00} : bt_new;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) bt_q <= '0;
		else if (!recovery_enable_q) bt_q <= {NOMINAL_BIT_TIME, 8'h00};
		else if (take) bt_q <= bt_clamped;
	end

	// registered status outputs
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			RECOVERY_ENABLE <= 1'b0;
			RECOVERY_CLOCK_SELECT <= '0;
			FILTER_CONSTANT <= '0;
			RECOVERY_TICK <= 1'b0;
			RECOVERED_BIT_TIME <= '0;
		end else begin
			RECOVERY_ENABLE <= recovery_enable_q;
			RECOVERY_CLOCK_SELECT <= recovery_clock_select_q;
			FILTER_CONSTANT <= 6'(7'h01 << shift_sel);
			RECOVERY_TICK <= tick;
			RECOVERED_BIT_TIME <= bt_q[15:8];
		end
	end
endmodule : wcr_top

// [tb/wcr_top_checker.sv]
// concurrent checks on the ports of the configuration block
module wcr_top_checker
	import wcr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic SOFT_RESET,
	input wire logic CSN,
	input wire logic SDO_OE_N,
	input wire logic [7:0] NOMINAL_BIT_TIME,
	input wire logic [7:0] BIT_TIME_UPPER_LIMIT,
	input wire logic [7:0] BIT_TIME_LOWER_LIMIT,
	input wire logic RECOVERY_ENABLE,
	input wire logic [1:0] RECOVERY_CLOCK_SELECT,
	input wire logic [5:0] FILTER_CONSTANT,
	input wire logic RECOVERY_TICK,
	input wire logic [7:0] RECOVERED_BIT_TIME
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);
	// a long quiet stretch on chip select, and the start of a frame
	sequence s_quiet;
		(CSN && !SOFT_RESET) [*8] ##1 (CSN && !SOFT_RESET) [*4];
	endsequence
	sequence s_frame_open;
		$fell(CSN) ##1 !CSN [*7];
	endsequence
	a_oe_frame_open: assert property (s_frame_open |-> !SDO_OE_N)
		else $error("output enable not active inside a frame");
	a_oe_idle_high: assert property (CSN [*8] |-> SDO_OE_N)
		else $error("output enable active outside a frame");
	a_config_holds: assert property (
		s_quiet |-> $stable(RECOVERY_CLOCK_SELECT) && $stable(RECOVERY_ENABLE))
		else $error("configuration changed without a frame");
	a_filter_legal: assert property (
		$past(RSTN) |-> FILTER_CONSTANT inside {6'h08, 6'h10, 6'h20})
		else $error("filter constant not 8, 16 or 32");
	a_tick_gated: assert property (
		RECOVERY_TICK |-> RECOVERY_ENABLE || $past(RECOVERY_ENABLE))
		else $error("recovery tick while disabled");
	a_slow_tick_gap: assert property (
		RECOVERY_TICK && RECOVERY_CLOCK_SELECT == 2'h3
		|=> (!RECOVERY_TICK || RECOVERY_CLOCK_SELECT != 2'h3) [*8])
		else $error("ticks too close at the slowest clock");
	a_fast_tick_gap: assert property (
		RECOVERY_TICK && RECOVERY_CLOCK_SELECT == 2'h0 |=> !RECOVERY_TICK [*2])
		else $error("ticks too close at the fastest clock");
	a_clamp_range: assert property (
		RECOVERY_ENABLE |-> RECOVERED_BIT_TIME <= BIT_TIME_UPPER_LIMIT
		&& RECOVERED_BIT_TIME >= BIT_TIME_LOWER_LIMIT)
		else $error("recovered bit time outside limits");
	a_idle_nominal: assert property (
		!RECOVERY_ENABLE [*4] |-> RECOVERED_BIT_TIME == NOMINAL_BIT_TIME)
		else $error("disabled bit time not nominal");
endmodule : wcr_top_checker
bind wcr_top wcr_top_checker i_wcr_top_checker (.CLOCK, .RSTN, .SOFT_RESET, .CSN, .SDO_OE_N,
	.NOMINAL_BIT_TIME, .BIT_TIME_UPPER_LIMIT, .BIT_TIME_LOWER_LIMIT, .RECOVERY_ENABLE,
	.RECOVERY_CLOCK_SELECT, .FILTER_CONSTANT, .RECOVERY_TICK, .RECOVERED_BIT_TIME);

// [tb/wcr_host_model.sv]
// serial host model: sends 16-bit register frames and gathers read data
module wcr_host_model (
	input wire logic clk,
	input wire logic sdo,
	output logic sclk,
	output logic csn,
	output logic sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus: clock low, chip select high
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		sdi = 1'b1;
	end
	// one frame, address lsb first, mode bit, data lsb first; called at a falling edge
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [15:0] f;
		f = {wd, w, a};
		rd = 8'h00;
		csn <= 1'b0;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			sdi <= f[i];
			repeat (8) @(negedge clk);
			if (i > 7) rd[i-8] = sdo;
			sclk <= 1'b1;
			repeat (8) @(negedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(negedge clk);
		csn <= 1'b1;
		sdi <= ~sdi; // released line no longer shows the last bit
		repeat (14) @(negedge clk);
	endtask : xfer
endmodule : wcr_host_model

// [tb/wcr_top_test.sv]
// self-checking bench for the wake clock recovery configuration block
module wcr_top_test
	import wcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK, RSTN, SOFT_RESET, SCLK, CSN, SDI, SDO, SDO_OE_N, CAL_LOAD, RXD;
	logic RECOVERY_ENABLE, RECOVERY_TICK;
	logic [7:0] CAL_HIGH_IN, CAL_LOW_IN, RECOVERED_BIT_TIME, rd;
	logic [1:0] RECOVERY_CLOCK_SELECT;
	logic [5:0] FILTER_CONSTANT;
	logic [7:0] NOMINAL_BIT_TIME, BIT_TIME_UPPER_LIMIT, BIT_TIME_LOWER_LIMIT;
	int num_errors = 0;
	int n_checks = 0;
	int cnt;
	int gap[3] = '{1000, 2500, 5000};
	// block under test; bit time and limits are driven by the main sequence
	wcr_top i_wcr_top (.CLOCK, .RSTN, .SOFT_RESET, .SCLK, .CSN, .SDI, .SDO, .SDO_OE_N,
		.CAL_LOAD, .CAL_HIGH_IN, .CAL_LOW_IN, .RXD, .NOMINAL_BIT_TIME,
		.BIT_TIME_UPPER_LIMIT, .BIT_TIME_LOWER_LIMIT, .RECOVERY_ENABLE,
		.RECOVERY_CLOCK_SELECT, .FILTER_CONSTANT, .RECOVERY_TICK, .RECOVERED_BIT_TIME);
	wcr_host_model i_wcr_host_model (.clk(CLOCK), .sdo(SDO), .sclk(SCLK), .csn(CSN), .sdi(SDI));
	// 250 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_wcr_host_model.xfer(a, 1'b1, d, rd);
	endtask : wr
	task automatic rdchk(input string what, input logic [6:0] a, input logic [7:0] exp);
		i_wcr_host_model.xfer(a, 1'b0, 8'h00, rd);
		check(what, rd, exp);
	endtask : rdchk
	// falling edges on the receive line, spaced cyc clocks apart
	task automatic rx(input int n, input int cyc);
		repeat (n) begin
			RXD <= 1'b0;
			repeat (cyc / 2) @(negedge CLOCK);
			RXD <= 1'b1;
			repeat (cyc / 2) @(negedge CLOCK);
		end
	endtask : rx
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial begin
		repeat (90000) @(posedge CLOCK);
		num_errors++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		RSTN = 1'b0;
		SOFT_RESET = 1'b0;
		CAL_LOAD = 1'b0;
		CAL_HIGH_IN = 8'h5a;
		CAL_LOW_IN = 8'ha5;
		RXD = 1'b1;
		NOMINAL_BIT_TIME = 8'ha0;
		BIT_TIME_UPPER_LIMIT = 8'ha8;
		BIT_TIME_LOWER_LIMIT = 8'h98;
		repeat (6) @(negedge CLOCK);
		RSTN <= 1'b1;
		repeat (2) @(negedge CLOCK);
		rdchk("cal_high", ADDR_CAL_HIGH, 8'h00);
		rdchk("cal_low", ADDR_CAL_LOW, 8'h00);
		rdchk("ctrl_one", ADDR_CTRL_ONE, 8'h04);
		rdchk("ctrl_two", ADDR_CTRL_TWO, 8'h00);
		check("filter", {2'h0, FILTER_CONSTANT}, 8'h10);
		// fixed filter selections, reserved bits written as ones
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_CTRL_ONE, 8'hf2 | 8'(s << 2));
			rdchk("ctrl_one", ADDR_CTRL_ONE, 8'(s << 2));
			check("filter", {2'h0, FILTER_CONSTANT}, 8'h08 << s);
		end
		// every recovery clock, ticks counted over one microsecond
		wr(ADDR_CTRL_ONE, 8'h01);
		check("enable", {7'h00, RECOVERY_ENABLE}, 8'h01);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CTRL_TWO, 8'hfc | 8'(s));
			rdchk("ctrl_two", ADDR_CTRL_TWO, 8'(s));
			check("clksel", {6'h00, RECOVERY_CLOCK_SELECT}, 8'(s));
			cnt = 0;
			repeat (250) begin
				@(negedge CLOCK);
				if (RECOVERY_TICK === 1'b1) cnt++;
			end
			check("ticks", 8'(cnt), 8'(80 >> s));
		end
		// slow bus at the fastest clock: bit time pulled above the upper limit
		wr(ADDR_CTRL_TWO, 8'h00);
		rx(24, 1100);
		check("bit_time", RECOVERED_BIT_TIME, 8'ha8);
		// adaptive constant from edge spacing of 2, 5 and 10 bits
		wr(ADDR_CTRL_ONE, 8'h0d);
		for (int k = 0; k < 3; k++) begin
			rx(3, gap[k]);
			check("adapt", {2'h0, FILTER_CONSTANT}, 8'h20 >> k);
		end
		// calibration bytes ignore writes; unmapped read gives zero
		CAL_LOAD <= 1'b1;
		@(negedge CLOCK);
		CAL_LOAD <= 1'b0;
		wr(ADDR_CAL_HIGH, 8'hff);
		wr(ADDR_CAL_LOW, 8'h00);
		rdchk("cal_high", ADDR_CAL_HIGH, 8'h5a);
		rdchk("cal_low", ADDR_CAL_LOW, 8'ha5);
		rdchk("unmapped", 7'h10, 8'h00);
		// soft reset restores the reset values
		wr(ADDR_CTRL_TWO, 8'h02);
		SOFT_RESET <= 1'b1;
		@(negedge CLOCK);
		SOFT_RESET <= 1'b0;
		rdchk("cal_low", ADDR_CAL_LOW, 8'h00);
		rdchk("ctrl_one", ADDR_CTRL_ONE, 8'h04);
		check("enable", {7'h00, RECOVERY_ENABLE}, 8'h00);
		rdchk("ctrl_two", ADDR_CTRL_TWO, 8'h00);
		// hard reset in mid-run, then bit time and limits for the halved clock ratio
		CAL_LOAD <= 1'b1;
		@(negedge CLOCK);
		CAL_LOAD <= 1'b0;
		RSTN <= 1'b0;
		NOMINAL_BIT_TIME <= 8'h50;
		BIT_TIME_UPPER_LIMIT <= 8'h54;
		BIT_TIME_LOWER_LIMIT <= 8'h4c;
		repeat (6) @(negedge CLOCK);
		RSTN <= 1'b1;
		repeat (2) @(negedge CLOCK);
		check("filter", {2'h0, FILTER_CONSTANT}, 8'h10);
		rdchk("cal_high", ADDR_CAL_HIGH, 8'h00);
		// fast bus at the 40 MHz clock: bit time pulled below the lower limit
		wr(ADDR_CTRL_TWO, 8'h01);
		wr(ADDR_CTRL_ONE, 8'h01);
		check("bit_time", RECOVERED_BIT_TIME, 8'h50);
		rx(12, 900);
		check("bit_time", RECOVERED_BIT_TIME, 8'h4c);
		tally_and_finish();
	end
endmodule : wcr_top_test
